// *** rtl/hpp_host_port.sv ***
// Host parallel port: host pins, CPU register port and DMA requests
`timescale 1ns/1ps
module hpp_host_port (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Host pins
  input  wire logic        host_chip_select_n,
  input  wire logic        host_data_strobe_one,
  input  wire logic        host_data_strobe_two,
  input  wire logic        host_read_not_write,
  input  wire logic [1:0]  host_register_select,
  input  wire logic        host_addr_latch_n,
  input  wire logic [31:0] host_data_in,
  output logic [31:0]      host_data_out,
  output logic             host_data_oe,
  output logic             host_wait_indication,
  // CPU register port
  input  wire logic        cpu_req,
  input  wire logic        cpu_we,
  input  wire logic [31:0] cpu_addr,
  input  wire logic [31:0] cpu_wdata,
  output logic [31:0]      cpu_rdata,
  output logic             cpu_ack,
  output logic             cpu_err,
  // DMA engine requests
  output logic             dma_req,
  output logic             dma_we,
  output logic [31:0]      dma_addr,
  output logic [31:0]      dma_wdata,
  input  wire logic        dma_ack,
  input  wire logic [31:0] dma_rdata,
  output logic [31:0]      dma_request_control
);

  typedef struct packed {
    hpp_pkg::hpp_state_t st;
    logic [31:0]         ctrl;
    logic [31:0]         wptr;
    logic [31:0]         rptr;
    logic [31:0]         trc;
    logic [31:0]         win;
    logic [31:0]         buf_data;
    logic [31:0]         buf_addr;
    logic                buf_full;
    logic                acc_rd;
    logic [1:0]          acc_sel;
    logic                lat_v;
    logic                lat_rd;
    logic [1:0]          lat_sel;
    logic                wait_o;
    logic [31:0]         hd_out;
    logic                hd_oe;
    logic                dreq;
    logic                dwe;
    logic [31:0]         daddr;
    logic [31:0]         dwdata;
    logic [31:0]         crdata;
    logic                cack;
    logic                cerr;
  } hpp_main_t;

  hpp_main_t   q;
  hpp_main_t   n;
  logic        strobe_fall;
  logic        strobe_rise;
  logic        latch_fall;
  logic        rw_s;
  logic [1:0]  sel_s;
  logic [31:0] data_hold;
  logic        rd_now;
  logic [1:0]  sel_now;

  function automatic logic is_data(input logic [1:0] sel);
    is_data = (sel == hpp_pkg::SEL_DATA_INC)
           || (sel == hpp_pkg::SEL_DATA_FIX);
  endfunction

  function automatic logic steps(input logic [1:0] sel,
                                 input logic [31:0] ctrl);
    steps = (sel == hpp_pkg::SEL_DATA_INC)
         && ctrl[hpp_pkg::CTRL_INC_BIT];
  endfunction

  function automatic logic [31:0] ctrl_view(input logic [31:0] ctrl,
                                            input logic buf_full);
    logic [31:0] v;
    v = ctrl & hpp_pkg::CTRL_WR_MASK;
    v[hpp_pkg::CTRL_BUSY_BIT] = buf_full;
    ctrl_view = v;
  endfunction

  hpp_pin_sync u_sync (
    .ref_clk              (ref_clk),
    .rst_n                (rst_n),
    .host_chip_select_n   (host_chip_select_n),
    .host_data_strobe_one (host_data_strobe_one),
    .host_data_strobe_two (host_data_strobe_two),
    .host_read_not_write  (host_read_not_write),
    .host_register_select (host_register_select),
    .host_addr_latch_n    (host_addr_latch_n),
    .host_data_in         (host_data_in),
    .strobe_fall          (strobe_fall),
    .strobe_rise          (strobe_rise),
    .latch_fall           (latch_fall),
    .rw_s                 (rw_s),
    .sel_s                (sel_s),
    .data_hold            (data_hold)
  );

  // Latched selects replace the live ones for this strobe period
  assign rd_now  = q.lat_v ? q.lat_rd  : rw_s;
  assign sel_now = q.lat_v ? q.lat_sel : sel_s;

  always_comb
  begin
    n      = q;
    n.cack = 1'b0;
    n.cerr = 1'b0;

    // DMA side: buffered write drains before any read, keeping order
    if (q.dreq && dma_ack)
    begin
      n.dreq = 1'b0;
      if (q.dwe)
      begin
        n.buf_full = 1'b0;
      end
      else if (q.st == hpp_pkg::ST_RD_DMA)
      begin
        n.win    = dma_rdata;
        n.hd_out = dma_rdata;
        n.wait_o = 1'b0;
        n.st     = hpp_pkg::ST_ACTIVE;
        if (steps(q.acc_sel, q.ctrl))
        begin
          n.rptr = q.rptr + hpp_pkg::ADDR_STEP;
        end
      end
    end
    else if (!q.dreq && q.buf_full)
    begin
      n.dreq   = 1'b1;
      n.dwe    = 1'b1;
      n.daddr  = q.buf_addr;
      n.dwdata = q.buf_data;
    end
    else if (!q.dreq && q.st == hpp_pkg::ST_RD_DMA)
    begin
      n.dreq  = 1'b1;
      n.dwe   = 1'b0;
      n.daddr = q.rptr;
    end

    // CPU register port; the data window has no address here
    if (cpu_req)
    begin
      n.cack = 1'b1;
      unique case (cpu_addr)
        hpp_pkg::CTRL_ADDR:
        begin
          n.crdata = ctrl_view(q.ctrl, q.buf_full);
          if (cpu_we)
          begin
            n.ctrl = cpu_wdata & hpp_pkg::CTRL_WR_MASK;
          end
        end
        hpp_pkg::WPTR_ADDR:
        begin
          n.crdata = q.wptr;
          if (cpu_we)
          begin
            n.wptr = cpu_wdata;
          end
        end
        hpp_pkg::RPTR_ADDR:
        begin
          n.crdata = q.rptr;
          if (cpu_we)
          begin
            n.rptr = cpu_wdata;
          end
        end
        hpp_pkg::TRC_ADDR:
        begin
          n.crdata = q.trc;
          if (cpu_we)
          begin
            n.trc = cpu_wdata;
          end
        end
        default:
        begin
          n.crdata = 32'h0000_0000;
          n.cerr   = 1'b1;
        end
      endcase
    end

    // Address latch strobe: one capture per strobe period
    if (latch_fall && !q.lat_v)
    begin
      n.lat_v   = 1'b1;
      n.lat_rd  = rw_s;
      n.lat_sel = sel_s;
    end

    // Host side; host writes win over CPU writes in the same cycle
    unique case (q.st)
      hpp_pkg::ST_IDLE:
      begin
        if (strobe_fall)
        begin
          n.acc_rd  = rd_now;
          n.acc_sel = sel_now;
          if (rd_now)
          begin
            n.hd_oe = 1'b1;
            if (is_data(sel_now))
            begin
              n.st = hpp_pkg::ST_RD_DMA;
            end
            else
            begin
              n.hd_out = (sel_now == hpp_pkg::SEL_CTRL)
                       ? ctrl_view(q.ctrl, q.buf_full)
                       : q.rptr;
              n.wait_o = 1'b0;
              n.st     = hpp_pkg::ST_ACTIVE;
            end
          end
          else if (is_data(sel_now) && q.buf_full)
          begin
            n.st = hpp_pkg::ST_WR_WAIT;
          end
          else
          begin
            n.wait_o = 1'b0;
            n.st     = hpp_pkg::ST_ACTIVE;
          end
        end
      end
      hpp_pkg::ST_RD_DMA:
      begin
        // Strobe released early: the fetch still completes but is
        // not presented
        if (strobe_rise)
        begin
          n.hd_oe = 1'b0;
          n.lat_v = 1'b0;
          n.st    = hpp_pkg::ST_IDLE;
        end
      end
      hpp_pkg::ST_WR_WAIT:
      begin
        if (strobe_rise)
        begin
          n.lat_v = 1'b0;
          n.st    = hpp_pkg::ST_IDLE;
        end
        else if (!q.buf_full)
        begin
          n.wait_o = 1'b0;
          n.st     = hpp_pkg::ST_ACTIVE;
        end
      end
      hpp_pkg::ST_ACTIVE:
      begin
        if (strobe_rise)
        begin
          n.hd_oe  = 1'b0;
          n.wait_o = 1'b1;
          n.lat_v  = 1'b0;
          n.st     = hpp_pkg::ST_IDLE;
          if (!q.acc_rd)
          begin
            if (q.acc_sel == hpp_pkg::SEL_CTRL)
            begin
              n.ctrl = data_hold & hpp_pkg::CTRL_WR_MASK;
            end
            else if (q.acc_sel == hpp_pkg::SEL_ADDR)
            begin
              n.wptr = data_hold;
              n.rptr = data_hold;
            end
            else
            begin
              n.win      = data_hold;
              n.buf_data = data_hold;
              n.buf_addr = q.wptr;
              n.buf_full = 1'b1;
              if (steps(q.acc_sel, q.ctrl))
              begin
                n.wptr = q.wptr + hpp_pkg::ADDR_STEP;
              end
            end
          end
        end
      end
      default:
      begin
        n.st = hpp_pkg::ST_IDLE;
      end
    endcase

    if (!rst_n)
    begin
      n        = '0;
      n.st     = hpp_pkg::ST_IDLE;
      n.ctrl   = hpp_pkg::CTRL_RESET;
      n.trc    = hpp_pkg::TRC_RESET;
      n.wptr   = hpp_pkg::PTR_RESET;
      n.rptr   = hpp_pkg::PTR_RESET;
      n.wait_o = 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    q <= n;
  end

  assign host_data_out        = q.hd_out;
  assign host_data_oe         = q.hd_oe;
  assign host_wait_indication = q.wait_o;
  assign cpu_rdata            = q.crdata;
  assign cpu_ack              = q.cack;
  assign cpu_err              = q.cerr;
  assign dma_req              = q.dreq;
  assign dma_we               = q.dwe;
  assign dma_addr             = q.daddr;
  assign dma_wdata            = q.dwdata;
  assign dma_request_control  = q.trc;

endmodule

// *** rtl/hpp_pin_sync.sv ***
// Pin synchroniser and strobe edge detector of the host parallel port
`timescale 1ns/1ps
module hpp_pin_sync (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Raw host pins
  input  wire logic        host_chip_select_n,
  input  wire logic        host_data_strobe_one,
  input  wire logic        host_data_strobe_two,
  input  wire logic        host_read_not_write,
  input  wire logic [1:0]  host_register_select,
  input  wire logic        host_addr_latch_n,
  input  wire logic [31:0] host_data_in,
  // Synchronised view
  output logic             strobe_fall,
  output logic             strobe_rise,
  output logic             latch_fall,
  output logic             rw_s,
  output logic [1:0]       sel_s,
  output logic [31:0]      data_hold
);

  typedef struct packed {
    logic [2:0]  stb1;
    logic [2:0]  stb2;
    logic        stb3;
    logic        lat1;
    logic        lat2;
    logic        lat3;
    logic        rw1;
    logic        rw2;
    logic [1:0]  sel1;
    logic [1:0]  sel2;
    logic [31:0] dat1;
    logic [31:0] dat2;
    logic [31:0] hold;
  } hpp_sync_t;

  hpp_sync_t q;
  hpp_sync_t n;
  logic      strobe_raw;

  // Active low combined strobe, formed after the synchronisers so that
  // skew between the three pins cannot glitch into one flop
  assign strobe_raw = ~(q.stb2[1] ^ q.stb2[0]) | q.stb2[2];

  always_comb
  begin
    n      = q;
    n.stb1 = {host_chip_select_n, host_data_strobe_one,
              host_data_strobe_two};
    n.stb2 = q.stb1;
    n.stb3 = strobe_raw;
    n.lat1 = host_addr_latch_n;
    n.lat2 = q.lat1;
    n.lat3 = q.lat2;
    n.rw1  = host_read_not_write;
    n.rw2  = q.rw1;
    n.sel1 = host_register_select;
    n.sel2 = q.sel1;
    n.dat1 = host_data_in;
    n.dat2 = q.dat1;
    // Data sampled while the strobe was still low, so the host hold
    // time after the rising strobe need not cover the sync delay
    if (!strobe_raw)
    begin
      n.hold = q.dat2;
    end
    if (!rst_n)
    begin
      n = '1;
      n.rw1  = 1'b0;
      n.rw2  = 1'b0;
      n.sel1 = 2'h0;
      n.sel2 = 2'h0;
      n.dat1 = 32'h0000_0000;
      n.dat2 = 32'h0000_0000;
      n.hold = 32'h0000_0000;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    q <= n;
  end

  assign strobe_fall = q.stb3 & ~strobe_raw;
  assign strobe_rise = ~q.stb3 & strobe_raw;
  assign latch_fall  = q.lat3 & ~q.lat2;
  assign rw_s        = q.rw2;
  assign sel_s       = q.sel2;
  assign data_hold   = q.hold;

endmodule

// *** rtl/hpp_pkg.sv ***
// Constants, encodings and states of the host parallel port
//
// Overview of operation
// - Host masters reads and writes of whole memory
// - All host memory traffic goes through DMA engine
// - Host and CPU both reach control and pointer
// - Data window reachable only by the host pins
// - Host pointer write loads both internal pointers
// - CPU reaches write and read pointers separately
// - Strobe is chip select OR inverted strobes XOR
// - Data read requests DMA, wait until window loaded
// - Host data write waits while write buffer is full
package hpp_pkg;

  // CPU-side register addresses
  localparam logic [31:0] CTRL_ADDR  = 32'h0188_0000;
  localparam logic [31:0] WPTR_ADDR  = 32'h0188_0004;
  localparam logic [31:0] RPTR_ADDR  = 32'h0188_0008;
  localparam logic [31:0] TRC_ADDR   = 32'h018A_0000;

  // Host register select codes
  localparam logic [1:0]  SEL_CTRL     = 2'h0;
  localparam logic [1:0]  SEL_ADDR     = 2'h1;
  localparam logic [1:0]  SEL_DATA_INC = 2'h2;
  localparam logic [1:0]  SEL_DATA_FIX = 2'h3;

  // Control register layout
  localparam int          CTRL_INC_BIT  = 0;
  localparam int          CTRL_BUSY_BIT = 1;
  localparam logic [31:0] CTRL_WR_MASK  = 32'h0000_0001;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0001;
  localparam logic [31:0] TRC_RESET     = 32'h0000_0000;
  localparam logic [31:0] PTR_RESET     = 32'h0000_0000;

  // Pointer step after an incrementing data window access, in bytes
  localparam logic [31:0] ADDR_STEP = 32'h0000_0004;

  // Host strobe timing, in clock periods
  localparam int STROBE_MIN_LOW_CYC  = 4;
  localparam int STROBE_MIN_HIGH_CYC = 4;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD_DMA,
    ST_WR_WAIT,
    ST_ACTIVE
  } hpp_state_t;

endpackage

// *** test/hpp_host_model.sv ***
// Behavioural external host that masters the strobe handshake
`timescale 1ns/1ps
module hpp_host_model (
  // Clock and device answer
  input  wire logic        ref_clk,
  input  wire logic        host_wait_indication,
  input  wire logic [31:0] host_data_out,
  // Host pins
  output logic             host_chip_select_n,
  output logic             host_data_strobe_one,
  output logic             host_data_strobe_two,
  output logic             host_read_not_write,
  output logic [1:0]       host_register_select,
  output logic             host_addr_latch_n,
  output logic [31:0]      host_data_in
);
  initial
  begin
    host_chip_select_n   = 1'b1;
    host_data_strobe_one = 1'b0;
    host_data_strobe_two = 1'b0;
    host_read_not_write  = 1'b1;
    host_register_select = 2'h0;
    host_addr_latch_n    = 1'b1; // Latch idle high, one pulse before a strobe with lat set
    host_data_in         = 32'h0000_0000;
  end
  // Reads strobe on the second data strobe, writes on the first
  // With lat set the selects are latched first, then the live lines lie
  task automatic access(input logic rd, input logic [1:0] sel,
                        input logic lat, input logic [31:0] wd,
                        output logic [31:0] rv);
    @(posedge ref_clk);
    host_read_not_write  <= rd;
    host_register_select <= sel;
    host_data_in         <= wd;
    if (lat)
    begin
      host_addr_latch_n    <= 1'b0;
      @(posedge ref_clk);
      host_addr_latch_n    <= 1'b1;
      host_register_select <= ~sel;
    end
    host_chip_select_n   <= 1'b0;
    host_data_strobe_one <= !rd;
    host_data_strobe_two <= rd;
    repeat (4) @(posedge ref_clk);
    // A hang here is caught by the bench cycle ceiling
    while (host_wait_indication !== 1'b0)
    begin
      @(posedge ref_clk);
    end
    rv = host_data_out;
    host_chip_select_n   <= 1'b1;
    host_data_strobe_one <= 1'b0;
    host_data_strobe_two <= 1'b0;
    // A released bus must not keep showing the last word
    host_data_in         <= ~wd;
    repeat (4) @(posedge ref_clk);
  endtask
endmodule

// *** test/hpp_host_port_bench.sv ***
// Self-checking bench of the host parallel port
`timescale 1ns/1ps
module hpp_host_port_bench;
  localparam logic [31:0] NIL = 32'h0000_0000;
  logic        ref_clk, rst_n, cpu_req, cpu_we, cpu_ack, cpu_err;
  logic        host_chip_select_n, host_data_strobe_one;
  logic        host_data_strobe_two, host_read_not_write;
  logic        host_addr_latch_n, host_data_oe, host_wait_indication;
  logic        dma_req, dma_we, dma_ack;
  logic [1:0]  host_register_select;
  logic [31:0] host_data_in, host_data_out, cpu_addr, cpu_wdata;
  logic [31:0] cpu_rdata, dma_addr, dma_wdata, dma_rdata;
  logic [31:0] dma_request_control, rv;
  logic [31:0] mem [logic [31:0]];
  int          num_errors, n_compared, cycles, dma_dly, dly_cnt;
  hpp_host_port i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n),
    .host_chip_select_n(host_chip_select_n),
    .host_data_strobe_one(host_data_strobe_one),
    .host_data_strobe_two(host_data_strobe_two),
    .host_read_not_write(host_read_not_write),
    .host_register_select(host_register_select),
    .host_addr_latch_n(host_addr_latch_n),
    .host_data_in(host_data_in), .host_data_out(host_data_out),
    .host_data_oe(host_data_oe),
    .host_wait_indication(host_wait_indication),
    .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_ack(cpu_ack),
    .cpu_err(cpu_err), .dma_req(dma_req), .dma_we(dma_we),
    .dma_addr(dma_addr), .dma_wdata(dma_wdata), .dma_ack(dma_ack),
    .dma_rdata(dma_rdata), .dma_request_control(dma_request_control)
  );
  hpp_host_model i_host (
    .ref_clk(ref_clk), .host_wait_indication(host_wait_indication),
    .host_data_out(host_data_out),
    .host_chip_select_n(host_chip_select_n),
    .host_data_strobe_one(host_data_strobe_one),
    .host_data_strobe_two(host_data_strobe_two),
    .host_read_not_write(host_read_not_write),
    .host_register_select(host_register_select),
    .host_addr_latch_n(host_addr_latch_n), .host_data_in(host_data_in)
  );
  always #4 ref_clk = ~ref_clk;
  // Memory behind the DMA engine; read data scrambles outside the ack
  always @(posedge ref_clk)
  begin
    if (dma_req && !dma_ack && dly_cnt < dma_dly)
      dly_cnt <= dly_cnt + 1;
    else if (dma_req && !dma_ack)
      dly_cnt <= 0;
    dma_ack   <= dma_req && !dma_ack && dly_cnt >= dma_dly;
    dma_rdata <= (dma_req && !dma_ack && !dma_we && dly_cnt >= dma_dly)
               ? mem[dma_addr] : ~dma_rdata;
    if (dma_req && !dma_ack && dma_we && dly_cnt >= dma_dly)
      mem[dma_addr] = dma_wdata;
  end
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      conclude();
    end
  end
  task automatic check(input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      num_errors++;
    end
  endtask
  task automatic conclude();
    $display("errors %0d, comparisons %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cpu_op(input logic we, input logic [31:0] a, d);
    @(posedge ref_clk);
    cpu_req   <= 1'b1;
    cpu_we    <= we;
    cpu_addr  <= a;
    cpu_wdata <= d;
    @(posedge ref_clk);
    cpu_req <= 1'b0;
    #1;
    check(32'(cpu_ack), 32'h0000_0001);
  endtask
  task automatic cpu_rd(input logic [31:0] a, ex);
    cpu_op(1'b0, a, ~ex);
    check(cpu_rdata, ex);
  endtask
  task automatic host(input logic rd, input logic [1:0] s,
                      input logic [31:0] d, ex, input logic lat = 1'b0);
    i_host.access(rd, s, lat, d, rv);
    #1;
    check(32'(host_data_oe), NIL);
    check(32'(host_wait_indication), 32'h0000_0001);
    if (rd)
      check(rv, ex);
  endtask
  task automatic t_reset();
    cpu_rd(hpp_pkg::CTRL_ADDR, hpp_pkg::CTRL_RESET);
    cpu_rd(hpp_pkg::WPTR_ADDR, hpp_pkg::PTR_RESET);
    cpu_rd(hpp_pkg::RPTR_ADDR, hpp_pkg::PTR_RESET);
    cpu_rd(hpp_pkg::TRC_ADDR, hpp_pkg::TRC_RESET);
    cpu_rd(32'h0188_000C, NIL);
    check(32'(cpu_err), 32'h0000_0001);
    cpu_op(1'b1, hpp_pkg::WPTR_ADDR, 32'h0000_0100);
    cpu_op(1'b1, hpp_pkg::RPTR_ADDR, 32'h0000_0200);
    cpu_rd(hpp_pkg::WPTR_ADDR, 32'h0000_0100);
    cpu_rd(hpp_pkg::RPTR_ADDR, 32'h0000_0200);
    cpu_op(1'b1, hpp_pkg::TRC_ADDR, 32'h0000_005A);
    cpu_rd(hpp_pkg::TRC_ADDR, 32'h0000_005A);
    check(dma_request_control, 32'h0000_005A);
  endtask
  task automatic t_host_regs();
    host(1'b0, hpp_pkg::SEL_ADDR, 32'h0000_1000, NIL);
    cpu_rd(hpp_pkg::WPTR_ADDR, 32'h0000_1000);
    cpu_rd(hpp_pkg::RPTR_ADDR, 32'h0000_1000);
    host(1'b1, hpp_pkg::SEL_ADDR, NIL, 32'h0000_1000);
    host(1'b0, hpp_pkg::SEL_CTRL, NIL, NIL);
    cpu_rd(hpp_pkg::CTRL_ADDR, NIL);
    cpu_op(1'b1, hpp_pkg::CTRL_ADDR, hpp_pkg::CTRL_RESET);
    host(1'b1, hpp_pkg::SEL_CTRL, NIL, hpp_pkg::CTRL_RESET);
  endtask
  // Slow engine so the second word meets a full write buffer
  task automatic t_host_write();
    dma_dly = 20;
    host(1'b0, hpp_pkg::SEL_DATA_INC, 32'hA1A1_0001, NIL);
    host(1'b0, hpp_pkg::SEL_DATA_INC, 32'hA1A1_0002, NIL);
    host(1'b0, hpp_pkg::SEL_DATA_FIX, 32'hA1A1_0003, NIL);
    repeat (2) @(posedge ref_clk);
    while (dma_req !== 1'b0 && cycles < 19000)
      @(posedge ref_clk);
    check(mem[32'h0000_1000], 32'hA1A1_0001);
    check(mem[32'h0000_1004], 32'hA1A1_0002);
    check(mem[32'h0000_1008], 32'hA1A1_0003);
    cpu_rd(hpp_pkg::WPTR_ADDR, 32'h0000_1008);
    cpu_rd(hpp_pkg::RPTR_ADDR, 32'h0000_1000);
  endtask
  task automatic t_host_read();
    dma_dly = 3;
    mem[32'h0000_2000] = 32'hB2B2_0001;
    mem[32'h0000_2004] = 32'hB2B2_0002;
    cpu_op(1'b1, hpp_pkg::RPTR_ADDR, 32'h0000_2000);
    host(1'b1, hpp_pkg::SEL_DATA_INC, NIL, 32'hB2B2_0001);
    host(1'b1, hpp_pkg::SEL_DATA_FIX, NIL, 32'hB2B2_0002);
    host(1'b1, hpp_pkg::SEL_DATA_INC, NIL, 32'hB2B2_0002);
    cpu_rd(hpp_pkg::RPTR_ADDR, 32'h0000_2008);
    cpu_rd(hpp_pkg::WPTR_ADDR, 32'h0000_1008);
  endtask
  // Live selects are inverted after the latch, so only latched ones pass
  task automatic t_latch();
    host(1'b0, hpp_pkg::SEL_ADDR, 32'h0000_3000, NIL, 1'b1);
    cpu_rd(hpp_pkg::WPTR_ADDR, 32'h0000_3000);
    host(1'b1, hpp_pkg::SEL_CTRL, NIL, hpp_pkg::CTRL_RESET, 1'b1);
  endtask
  initial
  begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    cpu_req = 1'b0;
    cpu_we = 1'b0;
    cpu_addr = NIL;
    cpu_wdata = NIL;
    dma_ack = 1'b0;
    dma_rdata = NIL;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_host_regs();
    t_host_write();
    t_host_read();
    t_latch();
    conclude();
  end
endmodule

// *** test/hpp_host_port_sva.sv ***
// Checker of the host parallel port boundary
`timescale 1ns/1ps
module hpp_host_port_sva (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_n,
  // Host pins
  input wire logic        host_chip_select_n,
  input wire logic        host_data_strobe_one,
  input wire logic        host_data_strobe_two,
  input wire logic        host_read_not_write,
  input wire logic [1:0]  host_register_select,
  input wire logic [31:0] host_data_out,
  input wire logic        host_data_oe,
  input wire logic        host_wait_indication,
  // CPU and DMA side
  input wire logic        cpu_req,
  input wire logic [31:0] cpu_addr,
  input wire logic [31:0] cpu_rdata,
  input wire logic        cpu_ack,
  input wire logic        cpu_err,
  input wire logic        dma_req,
  input wire logic        dma_we,
  input wire logic [31:0] dma_addr,
  input wire logic        dma_ack,
  input wire logic [31:0] dma_rdata
);
  default clocking dcb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  logic stb_n;
  logic mapped;
  assign stb_n = ~(host_data_strobe_one ^ host_data_strobe_two)
                 | host_chip_select_n;
  assign mapped = cpu_addr inside {hpp_pkg::CTRL_ADDR, hpp_pkg::WPTR_ADDR,
                                   hpp_pkg::RPTR_ADDR, hpp_pkg::TRC_ADDR};
  sequence s_rd_busy;
    dma_req && !dma_we;
  endsequence
  sequence s_rd_done;
    s_rd_busy ##0 dma_ack;
  endsequence
  dma_hold_a: assert property (
    dma_req && !dma_ack |=> dma_req && $stable(dma_addr) && $stable(dma_we))
    else $error("dma request changed before ack");
  dma_done_a: assert property (dma_req && dma_ack |=> !dma_req)
    else $error("dma request held after ack");
  cpu_ack_a: assert property (cpu_req && mapped |=> cpu_ack && !cpu_err)
    else $error("cpu access not acknowledged");
  cpu_err_a: assert property (
    cpu_req && !mapped |=> cpu_err && cpu_rdata == 32'h0000_0000)
    else $error("unmapped cpu access not refused");
  oe_read_a: assert property (
    $rose(host_data_oe) |-> host_read_not_write && !stb_n)
    else $error("data driven outside a host read");
  wait_fall_a: assert property ($fell(host_wait_indication) |-> !stb_n)
    else $error("ready given without active strobe");
  wait_rise_a: assert property (
    $rose(stb_n) |-> ##[1:6] host_wait_indication)
    else $error("ready not withdrawn after strobe rise");
  read_wait_a: assert property (s_rd_busy |-> host_wait_indication)
    else $error("ready given while read fetch pending");
  read_ready_a: assert property (
    s_rd_done |=> !host_wait_indication && host_data_out == $past(dma_rdata))
    else $error("read data not presented after fetch");
  oe_stand_a: assert property (
    host_read_not_write && !stb_n && !host_wait_indication |-> host_data_oe)
    else $error("read ready given without data driven");
  wbuf_full_a: assert property (
    dma_req && dma_we && !stb_n && !host_read_not_write &&
    host_register_select[1] |-> host_wait_indication)
    else $error("ready given with write buffer full");
endmodule
bind hpp_host_port hpp_host_port_sva i_sva (
  .ref_clk(ref_clk), .rst_n(rst_n),
  .host_chip_select_n(host_chip_select_n),
  .host_data_strobe_one(host_data_strobe_one),
  .host_data_strobe_two(host_data_strobe_two),
  .host_read_not_write(host_read_not_write),
  .host_register_select(host_register_select),
  .host_data_out(host_data_out), .host_data_oe(host_data_oe),
  .host_wait_indication(host_wait_indication),
  .cpu_req(cpu_req), .cpu_addr(cpu_addr), .cpu_rdata(cpu_rdata),
  .cpu_ack(cpu_ack), .cpu_err(cpu_err), .dma_req(dma_req),
  .dma_we(dma_we), .dma_addr(dma_addr), .dma_ack(dma_ack),
  .dma_rdata(dma_rdata)
);
